//--- hdl/tcm_pkg.sv
// Package for the timer channel mode control block: map, fields, modes
package tcm_pkg;

    // Register byte addresses on the APB bus
    localparam logic [7:0] TCM_ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] TCM_ADDR_CHANNEL_VALUE  = 8'h04;
    localparam logic [7:0] TCM_ADDR_TIMER_CONTROL  = 8'h08;

    // Field positions inside the channel status/control register
    localparam int TCM_BIT_EVENT_FLAG = 7;
    localparam int TCM_BIT_IRQ_ENABLE = 6;
    localparam int TCM_BIT_MODE_HIGH  = 5;
    localparam int TCM_BIT_MODE_LOW   = 4;
    localparam int TCM_BIT_ELS_HIGH   = 3;
    localparam int TCM_BIT_ELS_LOW    = 2;

    // Field position of the center-align select in the timer control register
    localparam int TCM_BIT_CENTER_ALIGN = 5;

    // Reset values
    localparam logic [7:0]  TCM_RST_STATUS_CONTROL = 8'h00;
    localparam logic [15:0] TCM_RST_CHANNEL_VALUE  = 16'h0000;
    localparam logic        TCM_RST_CENTER_ALIGN   = 1'b0;
    localparam logic        TCM_RST_PIN_LEVEL      = 1'b0;

    // Edge/level select encodings
    localparam logic [1:0] TCM_ELS_RELEASED = 2'h0;
    localparam logic [1:0] TCM_ELS_RISE     = 2'h1;
    localparam logic [1:0] TCM_ELS_FALL     = 2'h2;
    localparam logic [1:0] TCM_ELS_BOTH     = 2'h3;

    // Pin synchroniser depth
    localparam int TCM_SYNC_STAGES = 3;

    // Channel operating mode
    typedef enum logic [1:0] {
        TCM_MODE_CAPTURE,
        TCM_MODE_COMPARE,
        TCM_MODE_EDGE_PWM,
        TCM_MODE_CENTER_PWM
    } tcm_mode_e;

    // Software-visible control fields of the channel
    typedef struct packed {
        logic       channel_irq_enable;
        logic       channel_mode_select_high;
        logic       channel_mode_select_low;
        logic [1:0] edge_level_select;
    } tcm_ctrl_s;

    // View of the shared counter as the channel sees it
    typedef struct packed {
        logic [15:0] value;
        logic        count_down;
        logic        tick;
        logic        wrap;
    } tcm_counter_s;

endpackage : tcm_pkg

//--- hdl/tcm_channel.sv
// Timer channel mode control: status/control register, modes, flag and pin
`timescale 1ns/1ps

module tcm_channel
    import tcm_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Shared counter
    input  wire tcm_counter_s       counter,
    output logic                    center_align_select,
    // Channel pin
    input  wire logic               channel_pin_in,
    output logic                    channel_pin_out,
    output logic                    channel_pin_oe,
    // Channel interrupt request
    output logic                    channel_irq
);

    // Register state
    logic                           event_flag_q;
    logic                           clear_armed_q;
    tcm_ctrl_s                      ctrl_q;
    logic [15:0]                    value_q;
    logic                           center_q;
    logic                           pin_q;
    logic                           pin_level_q;
    logic [31:0]                    prdata_q;
    logic [TCM_SYNC_STAGES-1:0]     pin_sync_q;

    // Decoded bus and channel conditions
    logic                           bus_access;
    logic                           bus_write;
    logic                           bus_read;
    logic                           hit_status;
    logic                           hit_value;
    logic                           hit_timer;
    logic                           addr_mapped;
    tcm_mode_e                      mode;
    logic                           pin_used;
    logic                           pin_agree;
    logic                           pin_rise;
    logic                           pin_fall;
    logic                           capture_event;
    logic                           match_event;
    logic                           channel_event;
    logic [7:0]                     status_view;

    // Address decode; every register answers at once, so no wait states
    assign hit_status  = (paddr == TCM_ADDR_STATUS_CONTROL);
    assign hit_value   = (paddr == TCM_ADDR_CHANNEL_VALUE);
    assign hit_timer   = (paddr == TCM_ADDR_TIMER_CONTROL);
    assign addr_mapped = hit_status | hit_value | hit_timer;
    assign bus_access  = psel & penable;
    assign bus_write   = bus_access & pwrite & addr_mapped;
    assign bus_read    = bus_access & ~pwrite & addr_mapped;
    assign pready      = 1'b1;
    assign pslverr     = bus_access & ~addr_mapped;
    assign prdata      = prdata_q;

    // Mode decode from center select and the two mode bits
    always_comb begin
        if (center_q) begin
            mode = TCM_MODE_CENTER_PWM;
        end else if (ctrl_q.channel_mode_select_high) begin
            mode = TCM_MODE_EDGE_PWM;
        end else if (ctrl_q.channel_mode_select_low) begin
            mode = TCM_MODE_COMPARE;
        end else begin
            mode = TCM_MODE_CAPTURE;
        end
    end

    // Pin belongs to the channel only with a nonzero edge/level select
    assign pin_used = (ctrl_q.edge_level_select != TCM_ELS_RELEASED);

    // Status byte as software reads it
    always_comb begin
        status_view                     = 8'h00;
        status_view[TCM_BIT_EVENT_FLAG] = event_flag_q;
        status_view[TCM_BIT_IRQ_ENABLE] = ctrl_q.channel_irq_enable;
        status_view[TCM_BIT_MODE_HIGH]  = ctrl_q.channel_mode_select_high;
        status_view[TCM_BIT_MODE_LOW]   = ctrl_q.channel_mode_select_low;
        status_view[TCM_BIT_ELS_HIGH]   = ctrl_q.edge_level_select[1];
        status_view[TCM_BIT_ELS_LOW]    = ctrl_q.edge_level_select[0];
    end

    // Pin synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_q <= '0;
        end else begin
            pin_sync_q <= {pin_sync_q[TCM_SYNC_STAGES-2:0], channel_pin_in};
        end
    end

    // Second and third stages must agree before a level is believed, so a
    // one-cycle glitch that slips past the first stage is never counted
    assign pin_agree = (pin_sync_q[TCM_SYNC_STAGES-2] == pin_sync_q[TCM_SYNC_STAGES-1]);

    // Accepted pin level; it moves only on an agreed change
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_level_q <= TCM_RST_PIN_LEVEL;
        end else if (pin_agree) begin
            pin_level_q <= pin_sync_q[TCM_SYNC_STAGES-1];
        end
    end

    // An edge is an agreed level that differs from the accepted one.
    // A pin that moves just before capture is chosen may still show an edge.
    assign pin_rise = pin_agree & pin_sync_q[TCM_SYNC_STAGES-1] & ~pin_level_q;
    assign pin_fall = pin_agree & ~pin_sync_q[TCM_SYNC_STAGES-1] & pin_level_q;

    // Capture edge selection
    always_comb begin
        capture_event = 1'b0;
        if (mode == TCM_MODE_CAPTURE) begin
            unique case (ctrl_q.edge_level_select)
                TCM_ELS_RISE:     capture_event = pin_rise;
                TCM_ELS_FALL:     capture_event = pin_fall;
                TCM_ELS_BOTH:     capture_event = pin_rise | pin_fall;
                TCM_ELS_RELEASED: capture_event = 1'b0;
            endcase
        end
    end

    // Compare match once per counter step, in every non-capture mode.
    // Center mode hits this on the way up and on the way down.
    assign match_event = (mode != TCM_MODE_CAPTURE) & counter.tick
                       & (counter.value == value_q);

    // Events set the flag even with the pin released
    assign channel_event = capture_event | match_event;

    // Event flag: event beats a simultaneous clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            event_flag_q <= TCM_RST_STATUS_CONTROL[TCM_BIT_EVENT_FLAG];
        end else if (channel_event) begin
            event_flag_q <= 1'b1;
        end else if (bus_write & hit_status & pstrb[0] & clear_armed_q
                     & ~pwdata[TCM_BIT_EVENT_FLAG]) begin
            event_flag_q <= 1'b0;
        end
    end

    // Clear arming: a read that returned a set flag arms, an event or a status write disarms.
    // Disarming on an event forces a fresh read, so no event is dropped.
    // The flag is judged from the byte loaded in the setup cycle, so an event
    // landing between setup and access can never be cleared unseen.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clear_armed_q <= 1'b0;
        end else if (channel_event) begin
            clear_armed_q <= 1'b0;
        end else if (bus_write & hit_status) begin
            clear_armed_q <= 1'b0;
        end else if (bus_read & hit_status & prdata_q[TCM_BIT_EVENT_FLAG]) begin
            clear_armed_q <= 1'b1;
        end
    end

    // Control fields; a written 1 in the flag position is simply dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q.channel_irq_enable       <= TCM_RST_STATUS_CONTROL[TCM_BIT_IRQ_ENABLE];
            ctrl_q.channel_mode_select_high <= TCM_RST_STATUS_CONTROL[TCM_BIT_MODE_HIGH];
            ctrl_q.channel_mode_select_low  <= TCM_RST_STATUS_CONTROL[TCM_BIT_MODE_LOW];
            ctrl_q.edge_level_select        <= TCM_ELS_RELEASED;
        end else if (bus_write & hit_status & pstrb[0]) begin
            ctrl_q.channel_irq_enable       <= pwdata[TCM_BIT_IRQ_ENABLE];
            ctrl_q.channel_mode_select_high <= pwdata[TCM_BIT_MODE_HIGH];
            ctrl_q.channel_mode_select_low  <= pwdata[TCM_BIT_MODE_LOW];
            ctrl_q.edge_level_select        <= pwdata[TCM_BIT_ELS_HIGH:TCM_BIT_ELS_LOW];
        end
    end

    // Center-align select, shared by all channels and the counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            center_q <= TCM_RST_CENTER_ALIGN;
        end else if (bus_write & hit_timer & pstrb[0]) begin
            center_q <= pwdata[TCM_BIT_CENTER_ALIGN];
        end
    end

    assign center_align_select = center_q;

    // Channel value: capture wins over a software write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= TCM_RST_CHANNEL_VALUE;
        end else if (capture_event) begin
            value_q <= counter.value;
        end else if (bus_write & hit_value) begin
            if (pstrb[0]) begin
                value_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                value_q[15:8] <= pwdata[15:8];
            end
        end
    end

    // Pin drive level per mode and edge/level select
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= TCM_RST_PIN_LEVEL;
        end else begin
            unique case (mode)
                TCM_MODE_CAPTURE: begin
                    pin_q <= pin_q;
                end
                TCM_MODE_COMPARE: begin
                    if (match_event) begin
                        unique case (ctrl_q.edge_level_select)
                            TCM_ELS_RELEASED: pin_q <= pin_q;
                            TCM_ELS_RISE:     pin_q <= ~pin_q;
                            TCM_ELS_FALL:     pin_q <= 1'b0;
                            TCM_ELS_BOTH:     pin_q <= 1'b1;
                        endcase
                    end
                end
                TCM_MODE_EDGE_PWM: begin
                    // Match ends the pulse; the wrap starts the next period
                    if (match_event) begin
                        pin_q <= ctrl_q.edge_level_select[0];
                    end else if (counter.wrap) begin
                        pin_q <= ~ctrl_q.edge_level_select[0];
                    end
                end
                TCM_MODE_CENTER_PWM: begin
                    // Up-count match ends the pulse, down-count match starts it
                    if (match_event) begin
                        pin_q <= counter.count_down
                               ? ~ctrl_q.edge_level_select[0]
                               : ctrl_q.edge_level_select[0];
                    end
                end
            endcase
        end
    end

    // Pin is driven only by output modes with a nonzero select
    assign channel_pin_out = pin_q;
    assign channel_pin_oe  = pin_used & (mode != TCM_MODE_CAPTURE);

    // Interrupt request follows flag and enable
    assign channel_irq = event_flag_q & ctrl_q.channel_irq_enable;

    // Read data captured in the setup phase, ready for the access phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            if (hit_status) begin
                prdata_q <= {24'h00_0000, status_view};
            end else if (hit_value) begin
                prdata_q <= {16'h0000, value_q};
            end else if (hit_timer) begin
                prdata_q <= {26'h000_0000, center_q, 5'h00};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

endmodule : tcm_channel

//--- testbench/tcm_channel_assertions.sv
// Port checker for the timer channel block
`timescale 1ns/1ps
module tcm_channel_assertions
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // APB request side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    // Outputs under watch
    input wire logic        center_align_select,
    input wire logic        channel_pin_oe,
    input wire logic        channel_irq
);
    localparam logic [7:0] SC = TCM_ADDR_STATUS_CONTROL;
    localparam logic [7:0] TC = TCM_ADDR_TIMER_CONTROL;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Accepted write; lane 0 carries every control byte
    sequence s_wr(logic [7:0] a);
        psel && penable && pready && pwrite && pstrb[0] && paddr == a;
    endsequence
    // A pending request only falls through a status write
    AST_IRQ_HOLDS: assert property (
        channel_irq && !(psel && penable && pwrite && paddr == SC) |=> channel_irq)
        else $error("interrupt dropped without a status write");
    AST_IRQ_MASKED: assert property (
        s_wr(SC) ##0 !pwdata[6] |=> !channel_irq)
        else $error("interrupt raised while disabled");
    // Pin drive follows the written mode and select code
    AST_PIN_RELEASED: assert property (
        s_wr(SC) ##0 (pwdata[3:2] == TCM_ELS_RELEASED) |=> !channel_pin_oe)
        else $error("released pin still driven");
    AST_CAPTURE_UNDRIVEN: assert property (
        s_wr(SC) ##0 (pwdata[5:4] == 2'h0 && !center_align_select) |=> !channel_pin_oe)
        else $error("capture channel drives its pin");
    AST_COMPARE_DRIVES: assert property (
        s_wr(SC) ##0 (pwdata[5:4] == 2'h1 && pwdata[3:2] != 2'h0) |=> channel_pin_oe)
        else $error("compare channel does not drive its pin");
    AST_PWM_DRIVES: assert property (
        s_wr(SC) ##0 (pwdata[5] && pwdata[3:2] != 2'h0) |=> channel_pin_oe)
        else $error("pwm channel does not drive its pin");
    // Center select moves only by a timer control write
    AST_CENTER_WRITE: assert property (
        s_wr(TC) |=> center_align_select == $past(pwdata[5]))
        else $error("center select not taken from the write");
    AST_CENTER_STEADY: assert property (
        !(psel && penable && pwrite && paddr == TC) |=> $stable(center_align_select))
        else $error("center select moved without a write");
    AST_RESET_QUIET: assert property (
        $rose(rst_n) |-> !channel_irq && !center_align_select && !channel_pin_oe)
        else $error("outputs not cleared by reset");
endmodule : tcm_channel_assertions

//--- testbench/tcm_pin_model.sv
// Behavioural model of the external source on the channel pin
`timescale 1ns/1ps
module tcm_pin_model
    import tcm_pkg::*;
(
    // Clock and requested source level
    input  wire logic clk_sys,
    input  wire logic ext_level,
    // Channel side of the pin
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level
);
    logic src_q;
    // Source moves just after an edge and then holds; the bench spaces the moves
    always_ff @(posedge clk_sys) begin
        src_q <= ext_level;
    end
    // Channel drive wins the wire, so the source never fights a driven pin
    assign pin_level = pin_oe ? pin_out : src_q;
endmodule : tcm_pin_model

//--- testbench/tcm_channel_test.sv
// Self-checking bench for the timer channel block
`timescale 1ns/1ps
module tcm_channel_test
    import tcm_pkg::*;
;
    localparam logic [7:0] ST = TCM_ADDR_STATUS_CONTROL;
    localparam logic [7:0] VL = TCM_ADDR_CHANNEL_VALUE;
    localparam logic [7:0] TC = TCM_ADDR_TIMER_CONTROL;
    // Bench-driven inputs, all defined at time zero
    logic         clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00, cfg;
    logic [31:0]  pwdata = 32'h0, prdata, q;
    logic [3:0]   pstrb = 4'hF;
    logic         ext_level = 1'b0, pready, pslverr, e, center_align_select;
    logic         pin_level, pin_out, pin_oe, channel_irq, old;
    tcm_counter_s cnt = '0;
    logic [15:0]  v, cv;
    int           bad_count = 0, check_count = 0;
    // Bus clock, 100 ns period
    always #50 clk_sys = ~clk_sys;
    tcm_channel dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter(cnt), .center_align_select(center_align_select),
        .channel_pin_in(pin_level), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
        .channel_irq(channel_irq));
    tcm_pin_model u_pin (.clk_sys(clk_sys), .ext_level(ext_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(pin_level));
    // Compare one value with its expectation and count the outcome
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; the request holds until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk_sys);
    endtask : apb
    // Present one counter step for a cycle, then give the channel time to react
    task automatic step(input logic tk, input logic wp, input logic dn, input logic [15:0] val);
        cnt <= '{val, dn, tk, wp};
        @(posedge clk_sys);
        cnt <= '{16'($urandom), dn, 1'b0, 1'b0};
        repeat (3) @(posedge clk_sys);
    endtask : step
    // Read with the flag set, then write it back as zero
    task automatic clear(input logic [7:0] c);
        apb(1'b0, ST, 32'h0);
        apb(1'b1, ST, c);
    endtask : clear
    // Read the status register; this read also arms a clear if it returns a set flag
    task automatic flag_is(input logic exp);
        apb(1'b0, ST, 32'h0);
        check("event flag", q[7], exp);
    endtask : flag_is
    // Compare pin after a match: toggle, clear or set, else unchanged
    function automatic logic cmp_pin(input logic [1:0] els, input logic prev);
        return els[1] ? els[0] : (els[0] ? !prev : prev);
    endfunction : cmp_pin
    // Print the tally and the verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Watchdog: over twenty times the expected run length
    initial begin
        #1000000;
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h0C07));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, ST, 32'h0);
        check("status reset", q[7:0], TCM_RST_STATUS_CONTROL);
        apb(1'b0, VL, 32'h0);
        check("value reset", q[15:0], TCM_RST_CHANNEL_VALUE);
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped error", e, 1'b1);
        repeat (3) begin
            cfg = 8'($urandom) | 8'h80;
            apb(1'b1, ST, cfg);
            apb(1'b0, ST, 32'h0);
            check("control readback", q[7:2], {1'b0, cfg[6:2]});
        end
        $display("reset and register test done");
        // Output compare: each pin action, flag, interrupt and clear sequence
        v = 16'($urandom);
        apb(1'b1, VL, {16'h0, v});
        for (int k = 0; k < 4; k++) begin
            cfg = {1'b0, 1'($urandom), 2'h1, 2'(k), 2'h0};
            apb(1'b1, ST, cfg);
            clear(cfg);
            old = pin_out;
            step(1'b1, 1'b0, 1'b0, v);
            flag_is(1'b1);
            check("irq", channel_irq, cfg[6]);
            if (k == 0)
                check("pin released", pin_oe, 1'b0);
            else
                check("compare pin", pin_out, cmp_pin(2'(k), old));
            apb(1'b1, ST, cfg | 8'h80);
            flag_is(1'b1);
            step(1'b1, 1'b0, 1'b0, v);
            apb(1'b1, ST, cfg);
            flag_is(1'b1);
            apb(1'b1, ST, cfg);
            step(1'b1, 1'b0, 1'b0, v + 16'h1);
            flag_is(1'b0);
        end
        $display("compare test done");
        // Input capture per edge choice; pin released and steady beforehand
        apb(1'b1, ST, 32'h0);
        for (int k = 1; k < 4; k++) begin
            cv = 16'($urandom);
            cnt <= '{cv, 1'b0, 1'b0, 1'b0};
            cfg = {4'h0, 2'(k), 2'h0};
            apb(1'b1, ST, cfg);
            clear(cfg);
            ext_level <= 1'b1;
            repeat (6) @(posedge clk_sys);
            flag_is(cfg[2]);
            apb(1'b0, VL, 32'h0);
            if (cfg[2])
                check("captured value", q[15:0], cv);
            clear(cfg);
            ext_level <= 1'b0;
            repeat (6) @(posedge clk_sys);
            flag_is(cfg[3]);
        end
        $display("capture test done");
        // PWM: edge mode leads with the period start, center mode with a down match
        apb(1'b1, VL, {16'h0, v});
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, TC, {26'h0, 1'(c), 5'h0});
            for (int k = 1; k < 4; k++) begin
                cfg = {2'h1, 1'b1, 1'($urandom), 2'(k), 2'h0};
                apb(1'b1, ST, cfg);
                step(1'(c), 1'(1 - c), 1'(c), v);
                check("pwm lead", pin_out, !cfg[2]);
                clear(cfg);
                step(1'b1, 1'b0, 1'b0, v);
                check("pwm match", pin_out, cfg[2]);
                flag_is(1'b1);
                check("pwm irq", channel_irq, 1'b1);
            end
        end
        apb(1'b1, TC, 32'h0);
        check("center off", center_align_select, 1'b0);
        $display("pwm test done");
        conclude();
    end
endmodule : tcm_channel_test
// Attach the port checker to every channel instance
bind tcm_channel tcm_channel_assertions u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .center_align_select(center_align_select), .channel_pin_oe(channel_pin_oe),
    .channel_irq(channel_irq));
